// [core/timer_pair_regs.vh]
// Register offsets, field positions, reset values and mode codes.
`ifndef TIMER_PAIR_REGS_VH
`define TIMER_PAIR_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WIDTH_CONFIG_OFS 8'h00
`define LOWER_MODE_OFS 8'h04
`define UPPER_MODE_OFS 8'h08
`define CONTROL_OFS 8'h0C
`define IRQ_MASK_OFS 8'h18
`define RAW_STATUS_OFS 8'h1C
`define MASKED_STATUS_OFS 8'h20
`define IRQ_CLEAR_OFS 8'h24
`define LOWER_LOAD_OFS 8'h28
`define UPPER_LOAD_OFS 8'h2C
`define LOWER_MATCH_OFS 8'h30
`define LOWER_PRESCALE_OFS 8'h38
`define UPPER_PRESCALE_OFS 8'h3C
`define LOWER_VALUE_OFS 8'h48
`define UPPER_VALUE_OFS 8'h4C

// ----------------------------------------------------------------
// Width configuration codes
// ----------------------------------------------------------------
`define CFG_32_TIMER 3'h0
`define CFG_32_CLOCK 3'h1
`define CFG_16_SPLIT 3'h4

// ----------------------------------------------------------------
// Half mode field codes
// ----------------------------------------------------------------
`define MODE_ONE_SHOT 2'h1
`define MODE_PERIODIC 2'h2

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define CTL_LOWER_EN 0
`define CTL_LOWER_STALL 1
`define CTL_CLOCK_EN 4
`define CTL_LOWER_TRIG 5
`define CTL_UPPER_EN 8
`define CTL_UPPER_STALL 9
`define CTL_UPPER_TRIG 13

// ----------------------------------------------------------------
// Status, mask and clear bit positions
// ----------------------------------------------------------------
`define IRQ_LOWER_TIMEOUT 0
`define IRQ_CLOCK_MATCH 3
`define IRQ_UPPER_TIMEOUT 8

// ----------------------------------------------------------------
// Reset values and clock-mode figures
// ----------------------------------------------------------------
`define COUNT_RESET 16'hFFFF
`define PRESCALE_RESET 8'h00
`define CLOCK_FIRST_LOAD 32'h00000001
`define CLOCK_IN_HZ 32768
`define CLOCK_OUT_HZ 1
`define CLOCK_DIVIDE (`CLOCK_IN_HZ / `CLOCK_OUT_HZ)

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [core/clock_tick_divider.v]
// Divides the synchronised 32.768 kHz capture pin down to a 1 Hz tick.
`timescale 1ns/1ps
`default_nettype none
module clock_tick_divider #(
  parameter DIVIDE = 32768
) (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire slow_clock,
  output reg tick
);

  reg sync_a;
  reg sync_b;
  reg sync_c;
  reg [15:0] edges;

  // ----------------------------------------------------------------
  // Edge counting
  // ----------------------------------------------------------------
  // The pin is slow and free of the system clock, so it is resynchronised
  // and only the second and third stages feed the edge detector.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      edges <= 16'h0000;
      tick <= 1'b0;
    end else begin
      sync_a <= slow_clock;
      sync_b <= sync_a;
      sync_c <= sync_b;
      tick <= 1'b0;
      if (!run) begin
        edges <= 16'h0000;
      end else if (sync_b && !sync_c) begin
        if (edges == DIVIDE[15:0] - 16'h0001) begin
          edges <= 16'h0000;
          tick <= 1'b1; // [RULE15]
        end else begin
          edges <= edges + 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [core/gp_timer_module.v]
// Timer pair: two 16-bit halves, chained 32-bit timer and clock, AXI4-Lite.
//
// Functional notes
// RULE1 - Reset clears control; counters and interval loads become all ones.
// RULE2 - Reset clears both prescale counters and prescale registers.
// RULE3 - Config 0 is 32-bit timer, config 1 is 32-bit clock, chained.
// RULE4 - Config 4 splits into two independent 16-bit timers.
// RULE5 - In 32-bit modes a lower load write fills both load registers.
// RULE6 - In 32-bit modes lower value read returns upper:lower counts.
// RULE7 - 32-bit timer is one down-counter; only lower mode field counts.
// RULE8 - 32-bit counter decrements, reloads from chained loads after zero.
// RULE9 - One-shot stops and clears its enable; periodic keeps counting.
// RULE10 - 32-bit time-out sets lower raw flag; masked flag when unmasked.
// RULE11 - Time-out emits a trigger only when lower trigger enable is set.
// RULE12 - Rewriting interval load reloads the running counter next cycle.
// RULE13 - Stall bit holds the counter until it is released.
// RULE14 - Clock mode counts up, starts at one; later loads via match.
// RULE15 - Capture pin carries 32.768 kHz, divided to a 1 Hz tick.
// RULE16 - Clock count equal to match rolls over to zero and continues.
// RULE17 - Clock match sets raw flag, masked flag if unmasked; clear both.
// RULE18 - Stall bits are ignored while clock mode enable is set.
// RULE19 - 16-bit halves count down with optional 8-bit prescaler.
// RULE20 - Half reloads load and prescale after zero; one-shot stops.
// RULE21 - Half time-out sets its raw flag, masked flag and trigger.
// RULE22 - Prescale p makes the half step once every p+1 clocks.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pair_regs.vh"
module gp_timer_module #(
  parameter CLOCK_DIVIDE = `CLOCK_DIVIDE
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire capture_pin_zero,
  output reg lower_trigger,
  output reg upper_trigger,
  output reg timer_irq
);

  // ----------------------------------------------------------------
  // Bus write channel capture
  // ----------------------------------------------------------------
  reg aw_got;
  reg w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_got | aw_hs;
  wire w_have = w_got | w_hs;
  wire wr_en = aw_have & w_have & ~s_axi_bvalid;
  wire [7:0] wr_addr = aw_got ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_got ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_got ? w_strb : s_axi_wstrb;
  wire next_aw_got = aw_have & ~wr_en;
  wire next_w_got = w_have & ~wr_en;
  reg wr_hit;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      if (aw_hs) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= ~next_aw_got;
      s_axi_wready <= ~next_w_got;
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [2:0] width_config_reg;
  reg [1:0] lower_mode_field;
  reg [1:0] upper_mode_field;
  reg lower_enable_bit;
  reg lower_stall_bit;
  reg clock_mode_enable;
  reg lower_trigger_enable;
  reg upper_enable_bit;
  reg upper_stall_bit;
  reg upper_trigger_enable;
  reg mask_lower;
  reg mask_clock;
  reg mask_upper;
  reg lower_timeout_raw;
  reg clock_match_raw;
  reg upper_timeout_raw;
  reg [15:0] lower_interval_load;
  reg [15:0] upper_interval_load;
  reg [15:0] lower_count_value;
  reg [15:0] upper_count_value;
  reg [7:0] lower_prescale_reg;
  reg [7:0] upper_prescale_reg;
  reg [7:0] lower_prescale_count;
  reg [7:0] upper_prescale_count;
  reg [31:0] lower_match_reg;
  wire clock_tick;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Counting conditions and events
  // ----------------------------------------------------------------
  wire mode_32 = (width_config_reg == `CFG_32_TIMER); // [RULE3]
  wire mode_clock = (width_config_reg == `CFG_32_CLOCK); // [RULE3]
  wire mode_split = (width_config_reg == `CFG_16_SPLIT); // [RULE4]
  wire [31:0] count_32 = {upper_count_value, lower_count_value};
  // Stall has no effect while clock mode enable is set.
  wire run_lower = lower_enable_bit &
                   ~(lower_stall_bit & ~clock_mode_enable); // [RULE13] [RULE18]
  wire run_upper = upper_enable_bit &
                   ~(upper_stall_bit & ~clock_mode_enable); // [RULE13] [RULE18]
  wire lower_step = (lower_prescale_count == 8'h00); // [RULE22]
  wire upper_step = (upper_prescale_count == 8'h00); // [RULE22]
  wire lower_timeout = mode_32 ? (run_lower & (count_32 == 32'h00000000))
                       : (mode_split & run_lower & lower_step &
                          (lower_count_value == 16'h0000)); // [RULE10]
  wire upper_timeout = mode_split & run_upper & upper_step &
                       (upper_count_value == 16'h0000); // [RULE21]
  wire clock_hit = mode_clock & lower_enable_bit & clock_tick &
                   (count_32 == lower_match_reg); // [RULE17]

  clock_tick_divider #(
    .DIVIDE(CLOCK_DIVIDE)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(mode_clock & lower_enable_bit),
    .slow_clock(capture_pin_zero),
    .tick(clock_tick)
  );

  // ----------------------------------------------------------------
  // Read view
  // ----------------------------------------------------------------
  reg [31:0] control_word;
  reg [31:0] raw_word;
  reg [31:0] mask_word;
  reg [31:0] rd_word;
  reg rd_hit;

  always @* begin
    control_word = 32'h00000000;
    control_word[`CTL_LOWER_EN] = lower_enable_bit;
    control_word[`CTL_LOWER_STALL] = lower_stall_bit;
    control_word[`CTL_CLOCK_EN] = clock_mode_enable;
    control_word[`CTL_LOWER_TRIG] = lower_trigger_enable;
    control_word[`CTL_UPPER_EN] = upper_enable_bit;
    control_word[`CTL_UPPER_STALL] = upper_stall_bit;
    control_word[`CTL_UPPER_TRIG] = upper_trigger_enable;
    raw_word = 32'h00000000;
    raw_word[`IRQ_LOWER_TIMEOUT] = lower_timeout_raw;
    raw_word[`IRQ_CLOCK_MATCH] = clock_match_raw;
    raw_word[`IRQ_UPPER_TIMEOUT] = upper_timeout_raw;
    mask_word = 32'h00000000;
    mask_word[`IRQ_LOWER_TIMEOUT] = mask_lower;
    mask_word[`IRQ_CLOCK_MATCH] = mask_clock;
    mask_word[`IRQ_UPPER_TIMEOUT] = mask_upper;
  end

  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `WIDTH_CONFIG_OFS: rd_word = {29'h0, width_config_reg};
      `LOWER_MODE_OFS: rd_word = {30'h0, lower_mode_field};
      `UPPER_MODE_OFS: rd_word = {30'h0, upper_mode_field};
      `CONTROL_OFS: rd_word = control_word;
      `IRQ_MASK_OFS: rd_word = mask_word;
      `RAW_STATUS_OFS: rd_word = raw_word;
      `MASKED_STATUS_OFS: rd_word = raw_word & mask_word; // [RULE10]
      `LOWER_LOAD_OFS: rd_word = mode_split ?
        {16'h0, lower_interval_load} :
        {upper_interval_load, lower_interval_load};
      `UPPER_LOAD_OFS: rd_word = {16'h0, upper_interval_load};
      `LOWER_MATCH_OFS: rd_word = lower_match_reg;
      `LOWER_PRESCALE_OFS: rd_word = {24'h0, lower_prescale_reg};
      `UPPER_PRESCALE_OFS: rd_word = {24'h0, upper_prescale_reg};
      `LOWER_VALUE_OFS: rd_word = mode_split ?
        {16'h0, lower_count_value} : count_32; // [RULE6]
      `UPPER_VALUE_OFS: rd_word = {16'h0, upper_count_value};
      `IRQ_CLEAR_OFS: rd_word = 32'h00000000;
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @* begin
    case (wr_addr)
      `WIDTH_CONFIG_OFS, `LOWER_MODE_OFS, `UPPER_MODE_OFS, `CONTROL_OFS,
      `IRQ_MASK_OFS, `IRQ_CLEAR_OFS, `LOWER_LOAD_OFS, `UPPER_LOAD_OFS,
      `LOWER_MATCH_OFS, `LOWER_PRESCALE_OFS, `UPPER_PRESCALE_OFS:
        wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters, register writes and flags
  // ----------------------------------------------------------------
  // Order inside this process matters: counting first, then software
  // writes, then hardware flag sets and enable clears, so a write of the
  // load register wins over a step and an event wins over its clear.
  wire [31:0] wv = merge(32'h00000000, wr_data, wr_strb);

  always @(posedge aclk) begin
    if (!aresetn) begin
      width_config_reg <= 3'h0; // [RULE1]
      lower_mode_field <= 2'h0;
      upper_mode_field <= 2'h0;
      lower_enable_bit <= 1'b0;
      lower_stall_bit <= 1'b0;
      clock_mode_enable <= 1'b0;
      lower_trigger_enable <= 1'b0;
      upper_enable_bit <= 1'b0;
      upper_stall_bit <= 1'b0;
      upper_trigger_enable <= 1'b0;
      mask_lower <= 1'b0;
      mask_clock <= 1'b0;
      mask_upper <= 1'b0;
      lower_timeout_raw <= 1'b0;
      clock_match_raw <= 1'b0;
      upper_timeout_raw <= 1'b0;
      lower_interval_load <= `COUNT_RESET; // [RULE1]
      upper_interval_load <= `COUNT_RESET; // [RULE1]
      lower_count_value <= `COUNT_RESET; // [RULE1]
      upper_count_value <= `COUNT_RESET; // [RULE1]
      lower_prescale_reg <= `PRESCALE_RESET; // [RULE2]
      upper_prescale_reg <= `PRESCALE_RESET; // [RULE2]
      lower_prescale_count <= `PRESCALE_RESET; // [RULE2]
      upper_prescale_count <= `PRESCALE_RESET; // [RULE2]
      lower_match_reg <= 32'h00000000;
      lower_trigger <= 1'b0;
      upper_trigger <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      if (mode_32 && run_lower) begin
        // One 32-bit down-counter; zero is held one cycle, then reload.
        if (count_32 == 32'h00000000) begin
          {upper_count_value, lower_count_value} <=
            {upper_interval_load, lower_interval_load}; // [RULE8]
        end else begin
          {upper_count_value, lower_count_value} <=
            count_32 - 32'h00000001; // [RULE7] [RULE8]
        end
      end
      if (mode_clock && lower_enable_bit && clock_tick) begin
        if (count_32 == lower_match_reg) begin
          {upper_count_value, lower_count_value} <= 32'h00000000; // [RULE16]
        end else begin
          {upper_count_value, lower_count_value} <=
            count_32 + 32'h00000001; // [RULE14]
        end
      end
      if (mode_split && run_lower) begin
        if (lower_step) begin
          lower_prescale_count <= lower_prescale_reg; // [RULE22]
          lower_count_value <= (lower_count_value == 16'h0000) ?
            lower_interval_load : lower_count_value - 16'h0001; // [RULE20]
        end else begin
          lower_prescale_count <= lower_prescale_count - 8'h01; // [RULE19]
        end
      end
      if (mode_split && run_upper) begin
        if (upper_step) begin
          upper_prescale_count <= upper_prescale_reg; // [RULE22]
          upper_count_value <= (upper_count_value == 16'h0000) ?
            upper_interval_load : upper_count_value - 16'h0001; // [RULE20]
        end else begin
          upper_prescale_count <= upper_prescale_count - 8'h01; // [RULE19]
        end
      end

      if (wr_en) begin
        case (wr_addr)
          `WIDTH_CONFIG_OFS: begin
            width_config_reg <= wv[2:0];
            if (wv[2:0] == `CFG_32_CLOCK && !mode_clock) begin
              {upper_count_value, lower_count_value} <=
                `CLOCK_FIRST_LOAD; // [RULE14]
            end
          end
          `LOWER_MODE_OFS: lower_mode_field <= wv[1:0];
          `UPPER_MODE_OFS: upper_mode_field <= wv[1:0];
          `CONTROL_OFS: begin
            lower_enable_bit <= wv[`CTL_LOWER_EN];
            lower_stall_bit <= wv[`CTL_LOWER_STALL];
            clock_mode_enable <= wv[`CTL_CLOCK_EN];
            lower_trigger_enable <= wv[`CTL_LOWER_TRIG];
            upper_enable_bit <= wv[`CTL_UPPER_EN];
            upper_stall_bit <= wv[`CTL_UPPER_STALL];
            upper_trigger_enable <= wv[`CTL_UPPER_TRIG];
          end
          `IRQ_MASK_OFS: begin
            mask_lower <= wv[`IRQ_LOWER_TIMEOUT];
            mask_clock <= wv[`IRQ_CLOCK_MATCH];
            mask_upper <= wv[`IRQ_UPPER_TIMEOUT];
          end
          `IRQ_CLEAR_OFS: begin
            if (wv[`IRQ_LOWER_TIMEOUT]) lower_timeout_raw <= 1'b0;
            if (wv[`IRQ_CLOCK_MATCH]) clock_match_raw <= 1'b0; // [RULE17]
            if (wv[`IRQ_UPPER_TIMEOUT]) upper_timeout_raw <= 1'b0;
          end
          `LOWER_LOAD_OFS: begin
            lower_interval_load <= wv[15:0];
            if (!mode_clock) begin
              lower_count_value <= wv[15:0]; // [RULE12]
            end
            if (!mode_split) begin
              upper_interval_load <= wv[31:16]; // [RULE5]
              if (!mode_clock) begin
                upper_count_value <= wv[31:16]; // [RULE12]
              end
            end
          end
          `UPPER_LOAD_OFS: begin
            upper_interval_load <= wv[15:0];
            if (mode_split) begin
              upper_count_value <= wv[15:0]; // [RULE12]
            end
          end
          `LOWER_MATCH_OFS: lower_match_reg <= wv;
          `LOWER_PRESCALE_OFS: lower_prescale_reg <= wv[7:0];
          `UPPER_PRESCALE_OFS: upper_prescale_reg <= wv[7:0];
          default: begin
          end
        endcase
      end

      if (lower_timeout) begin
        lower_timeout_raw <= 1'b1; // [RULE10] [RULE21]
        if (lower_mode_field == `MODE_ONE_SHOT) begin
          lower_enable_bit <= 1'b0; // [RULE9] [RULE20]
        end
      end
      if (upper_timeout) begin
        upper_timeout_raw <= 1'b1; // [RULE21]
        if (upper_mode_field == `MODE_ONE_SHOT) begin
          upper_enable_bit <= 1'b0; // [RULE20]
        end
      end
      if (clock_hit) begin
        clock_match_raw <= 1'b1; // [RULE17]
      end
      lower_trigger <= lower_timeout & lower_trigger_enable; // [RULE11]
      upper_trigger <= upper_timeout & upper_trigger_enable; // [RULE21]
      timer_irq <= |(raw_word & mask_word); // [RULE17] [RULE21]
    end
  end

endmodule
`default_nettype wire

// [test/slow_clock_source.sv]
// Partner model: the slow reference clock on the capture pin.
`timescale 1ns/1ps
`default_nettype none
module slow_clock_source #(
  parameter real HALF_NS = 100.0
) (
  output var logic pin
);
  // The rate is scaled up with the shortened divider so ticks fit a short
  // run; the reference runs free, as a crystal source does.
  initial pin = 1'b0;
  always #(HALF_NS) pin = ~pin;
endmodule
`default_nettype wire

// [test/gp_timer_module_chk.sv]
// Bus handshake and flag checks bound onto the timer pair.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pair_regs.vh"
module gp_timer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lower_trigger,
  input wire logic upper_trigger,
  input wire logic timer_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RESET_QUIET: assert property (
    $rose(aresetn) |-> !timer_irq && !lower_trigger && !upper_trigger)
    else $error("outputs active just after reset");
  AST_AW_TAKEN: assert property (
    s_axi_awvalid && s_axi_awready && !s_axi_bvalid |=>
    s_axi_awready == s_axi_bvalid)
    else $error("awready does not follow write commit after address taken");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stayed after handshake");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid ##[1:2] s_axi_arready)
    else $error("read channel did not recover");
  AST_UNMAPPED_READ: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h10 |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  AST_IRQ_CLEAR: assert property (
    $fell(timer_irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("irq dropped without a register write");
endmodule
bind gp_timer_module gp_timer_chk u_gp_timer_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .lower_trigger(lower_trigger), .upper_trigger(upper_trigger),
  .timer_irq(timer_irq));
`default_nettype wire

// [test/test_gp_timer_module.sv]
// Self-checking bench for the timer pair over its register bus.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pair_regs.vh"
module test_gp_timer_module;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] strb = 4'hF;
  wire logic awready, wready, bvalid, arready, rvalid, pin;
  wire logic ltrig, utrig, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int errors = 0, cmp_count = 0, cyc = 0, seed = 83945;
  logic [31:0] exp_q[$];
  string name_q[$];
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  slow_clock_source u_slow_clock_source (.pin(pin));
  gp_timer_module #(.CLOCK_DIVIDE(4)) u_gp_timer_module (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_pin_zero(pin), .lower_trigger(ltrig),
    .upper_trigger(utrig), .timer_irq(irq));
  // ----------------------------------------------------------------
  // Bus tasks and result checking
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 3000) begin
      check("wait bound", 32'h1, 32'h0);
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    strb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    check("bresp", {30'h0, bresp}, {30'h0, `RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    name_q.push_back($sformatf("reg %h", a));
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
  endtask
  // Waits for lower trigger (0), upper trigger (1) or the irq level (2).
  task automatic wait_on(input int sel, output int t);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!(sel == 0 ? ltrig : sel == 1 ? utrig : irq));
    t = cyc;
  endtask
  always @(posedge aclk)
    if (rvalid && rready) check(name_q.pop_front(), rdata, exp_q.pop_front());
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int t0, t1, t2, n;
    logic [31:0] r;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    bready <= 1'b1;
    rready <= 1'b1;
    r = $random(seed);
    rd(`LOWER_LOAD_OFS, 32'hFFFFFFFF);
    rd(`LOWER_VALUE_OFS, 32'hFFFFFFFF);
    rd(`LOWER_PRESCALE_OFS, 32'h0);
    rd(`UPPER_PRESCALE_OFS, 32'h0);
    rd(`CONTROL_OFS, 32'h0);
    rd(8'h10, 32'h0);
    wr(`IRQ_MASK_OFS, 32'h109, 4'h2);
    rd(`IRQ_MASK_OFS, 32'h100);
    wr(`IRQ_MASK_OFS, 32'h109);
    wr(`LOWER_LOAD_OFS, r);
    rd(`UPPER_LOAD_OFS, {16'h0, r[31:16]});
    rd(`LOWER_VALUE_OFS, r);
    wr(`LOWER_MODE_OFS, 32'h1);
    wr(`UPPER_MODE_OFS, 32'h2);
    wr(`LOWER_LOAD_OFS, 32'h5);
    wr(`CONTROL_OFS, 32'h21);
    wait_on(0, t0);
    rd(`CONTROL_OFS, 32'h20);
    rd(`LOWER_VALUE_OFS, 32'h5);
    rd(`RAW_STATUS_OFS, 32'h1);
    rd(`MASKED_STATUS_OFS, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    wr(`IRQ_CLEAR_OFS, 32'h1);
    rd(`RAW_STATUS_OFS, 32'h0);
    wr(`LOWER_MODE_OFS, 32'h2);
    wr(`LOWER_LOAD_OFS, 32'h7);
    wr(`CONTROL_OFS, 32'h21);
    wait_on(0, t1);
    wait_on(0, t2);
    check("period", 32'(t2 - t1), 32'd8);
    wr(`CONTROL_OFS, 32'h1);
    n = 0;
    repeat (20) begin
      @(posedge aclk);
      if (ltrig) n++;
    end
    check("trigger off", 32'(n), 32'h0);
    wr(`CONTROL_OFS, 32'h3);
    wr(`LOWER_LOAD_OFS, 32'h100);
    rd(`LOWER_VALUE_OFS, 32'h100);
    rd(`LOWER_VALUE_OFS, 32'h100);
    wr(`CONTROL_OFS, 32'h13);
    rd(`LOWER_VALUE_OFS, 32'hFF);
    wr(`CONTROL_OFS, 32'h0);
    wr(`WIDTH_CONFIG_OFS, 32'h4);
    wr(`UPPER_MODE_OFS, 32'h1);
    wr(`LOWER_PRESCALE_OFS, 32'h2);
    wr(`LOWER_LOAD_OFS, 32'h3);
    wr(`UPPER_LOAD_OFS, 32'h2);
    wr(`IRQ_CLEAR_OFS, 32'h109);
    wr(`CONTROL_OFS, 32'h2121);
    wait_on(1, t0);
    wait_on(0, t1);
    wait_on(0, t2);
    check("split period", 32'(t2 - t1), 32'd12);
    rd(`CONTROL_OFS, 32'h2021);
    rd(`UPPER_VALUE_OFS, 32'h2);
    rd(`MASKED_STATUS_OFS, 32'h101);
    wr(`CONTROL_OFS, 32'h0);
    wr(`IRQ_CLEAR_OFS, 32'h109);
    wr(`WIDTH_CONFIG_OFS, 32'h1);
    rd(`LOWER_VALUE_OFS, 32'h1);
    wr(`LOWER_MATCH_OFS, 32'h3);
    wr(`CONTROL_OFS, 32'h13);
    wait_on(2, t0);
    rd(`RAW_STATUS_OFS, 32'h8);
    rd(`LOWER_VALUE_OFS, 32'h0);
    wr(`IRQ_CLEAR_OFS, 32'h8);
    rd(`MASKED_STATUS_OFS, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
